/* lcf_pkg.sv */
package lcf_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_BITS = 12;
    localparam int PWM_HZ = 610;
    localparam int PWM_PRESC = CLK_HZ / (PWM_HZ * (2 ** PWM_BITS));
    localparam int SAMPLE_HZ = 100;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam real REV_HOLD_S = 0.1;
    localparam int REV_HOLD_CYC = int'($ceil(REV_HOLD_S * CLK_HZ));
    localparam int RST_MIN_US = 10;
    localparam int RST_MIN_CYC = RST_MIN_US * (CLK_HZ / 1_000_000);
    localparam int ADDR_BITS = 7;
    localparam logic [4:0] ADDR_UPPER = 5'h15;
    localparam int ERR_BITS = 3;
    localparam int STEP_BITS = 8;
    localparam logic [STEP_BITS-1:0] HUE_RST = 8'h00;
    localparam logic [STEP_BITS-1:0] LUM_RST = 8'h80;
    localparam logic DIR_RST = 1'b1;
    localparam logic [2:0] PWM_RST = 3'h0;

    typedef enum logic [1:0] {LCF_BTN_IDLE, LCF_BTN_HOLD, LCF_BTN_DONE} lcf_btn_e;

    // Hue wraps round the slider, brightness saturates at both ends
    function automatic logic [STEP_BITS-1:0] lcf_step(input logic [STEP_BITS-1:0] cur, input logic up,
                                                       input logic wrap);
        logic [STEP_BITS-1:0] res;
        res = cur;
        if (up) begin
            if (cur != {STEP_BITS{1'b1}} || wrap) begin
                res = cur + 8'h01;
            end
        end else begin
            if (cur != {STEP_BITS{1'b0}} || wrap) begin
                res = cur - 8'h01;
            end
        end
        return res;
    endfunction : lcf_step
endpackage : lcf_pkg

/* lcf_pwm_if.sv */
`timescale 1ns/100ps
interface lcf_pwm_if #(parameter int W = 12);
    logic [2:0][W-1:0] duty;
    logic run;
    logic polarity;
    logic en;
    logic [2:0] pwm;
    logic period_start;
    modport gen (input duty, input run, input polarity, input en, output pwm, output period_start);
    modport ctl (output duty, output run, output polarity, output en, input pwm, input period_start);
endinterface : lcf_pwm_if

/* lcf_pwm_gen.sv */
`timescale 1ns/100ps
module lcf_pwm_gen #(
    parameter int PRESC = lcf_pkg::PWM_PRESC,
    parameter int W = lcf_pkg::PWM_BITS
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    lcf_pwm_if.gen pif
);
    import lcf_pkg::*;

    localparam int PW = (PRESC > 1) ? $clog2(PRESC) : 1;

    typedef struct packed {
        logic [PW-1:0] presc;
        logic [W-1:0] cnt;
        logic [2:0][W-1:0] duty;
        logic [2:0] pwm;
        logic period_start;
    } lcf_gen_s;

    lcf_gen_s st_ff;
    lcf_gen_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.period_start = 1'b0;
        // A low enable stands for the gated core clock: everything but period_start holds
        if (pif.en) begin
            if (st_ff.presc == PW'(PRESC - 1)) begin // RULE_15
                nxt_st.presc = '0;
                nxt_st.cnt = st_ff.cnt + 1'b1; // RULE_22
                if (st_ff.cnt == {W{1'b1}}) begin
                    // New duty only at the period boundary, so no period is cut short
                    nxt_st.duty = pif.duty; // RULE_22
                    nxt_st.period_start = 1'b1;
                end
            end else begin
                nxt_st.presc = st_ff.presc + 1'b1;
            end
            for (int i = 0; i < 3; i++) begin
                // Idle level equals the polarity bit; asserted level is its inverse
                nxt_st.pwm[i] = pif.polarity ^ (pif.run && (nxt_st.cnt < nxt_st.duty[i])); // RULE_13 RULE_14 RULE_20
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_ff <= '{presc: '0, cnt: '0, duty: '0, pwm: PWM_RST, period_start: 1'b0}; // RULE_19
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pif.pwm = st_ff.pwm; // RULE_12
    assign pif.period_start = st_ff.period_start;

    property p_pwm_reset_low;
        @(posedge sys_clk_i) disable iff (reset_i) $past(reset_i) |-> st_ff.pwm == PWM_RST;
    endproperty
    a_pwm_reset_low: assert property (p_pwm_reset_low) else $error("PWM not low after reset"); // RULE_19

    property p_pwm_idle;
        @(posedge sys_clk_i) disable iff (reset_i)
            ($past(pif.en) && !$past(pif.run)) |-> st_ff.pwm == {3{$past(pif.polarity)}};
    endproperty
    a_pwm_idle: assert property (p_pwm_idle) else $error("PWM not at idle level while stopped"); // RULE_14

    property p_duty_at_boundary;
        @(posedge sys_clk_i) disable iff (reset_i) $changed(st_ff.duty) |-> st_ff.cnt == '0;
    endproperty
    a_duty_at_boundary: assert property (p_duty_at_boundary) else $error("Duty changed mid period"); // RULE_22

    property p_pwm_compare;
        @(posedge sys_clk_i) disable iff (reset_i)
            pif.run && pif.en && !pif.polarity ##1 1'b1 |-> st_ff.pwm[0] == (st_ff.cnt < st_ff.duty[0]);
    endproperty
    a_pwm_compare: assert property (p_pwm_compare) else $error("Red PWM does not follow compare"); // RULE_13

    property p_period_step;
        @(posedge sys_clk_i) disable iff (reset_i)
            $changed(st_ff.cnt) |-> $past(st_ff.presc) == PW'(PRESC - 1);
    endproperty
    a_period_step: assert property (p_period_step) else $error("Period counter stepped off prescale"); // RULE_15
endmodule : lcf_pwm_gen

/* lcf_ctrl_top.sv */
`timescale 1ns/100ps
// Overview of operation
// [RULE_01] System reset forces every register to its reset value while held.
// [RULE_02] Outside logic holds system reset for at least 10 microseconds.
// [RULE_03] Low-power request powers analog down and freezes all core activity.
// [RULE_04] Clock select 0 picks internal oscillator, 1 picks the external clock.
// [RULE_05] Address straps give the two low address bits, high strap more significant.
// [RULE_06] Upper five slave address bits are fixed at 10101.
// [RULE_07] The serial logic controls when the data pin is driven.
// [RULE_08] Hue button alone steps colour one way along the slider.
// [RULE_09] Both buttons held 0.1 second reverse the stepping direction.
// [RULE_10] After a reversal the hue button steps the slider the other way.
// [RULE_11] Luminance button alone raises or lowers brightness by current direction.
// [RULE_12] Three PWM outputs for red, green and blue, 12-bit duty each.
// [RULE_13] Each PWM output is asserted for the LED on-time of each period.
// [RULE_14] Polarity bit selects the asserted level of all three PWM outputs.
// [RULE_15] PWM periods repeat at about 610 Hz.
// [RULE_16] Error flag goes high whenever any error condition is present.
// [RULE_17] Current error kind is readable as status; host reads it after the flag.
// [RULE_18] Reference-select bit switches converter reference to the external input.
// [RULE_19] After reset the PWM outputs idle low since polarity resets low.
// [RULE_20] PWM runs only after the host sets the run bit.
// [RULE_21] Sampling and duty update repeat at about 100 Hz in operation.
// [RULE_22] Free 12-bit counter compared with duty; duty updated at period boundaries.
module lcf_ctrl_top #(
    parameter int SAMPLE_CYC_P = lcf_pkg::SAMPLE_CYC,
    parameter int REV_HOLD_CYC_P = lcf_pkg::REV_HOLD_CYC,
    parameter int PWM_PRESC_P = lcf_pkg::PWM_PRESC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic low_power_req_i,
    input wire logic clk_sel_i,
    input wire logic addr_strap_hi_i,
    input wire logic addr_strap_lo_i,
    input wire logic sda_i,
    input wire logic sda_drive_low_req_i,
    input wire logic hue_step_button_i,
    input wire logic luminance_step_button_i,
    input wire logic pwm_polarity_bit_i,
    input wire logic pwm_run_bit_i,
    input wire logic reference_source_bit_i,
    input wire logic [lcf_pkg::PWM_BITS-1:0] duty_red_i,
    input wire logic [lcf_pkg::PWM_BITS-1:0] duty_green_i,
    input wire logic [lcf_pkg::PWM_BITS-1:0] duty_blue_i,
    input wire logic [lcf_pkg::ERR_BITS-1:0] err_cond_i,
    output logic pwm_red_o,
    output logic pwm_green_o,
    output logic pwm_blue_o,
    output logic pwm_period_start_o,
    output logic err_flag_o,
    output logic [lcf_pkg::ERR_BITS-1:0] error_status_o,
    output logic [lcf_pkg::ADDR_BITS-1:0] slave_addr_o,
    output logic sda_o,
    output logic sda_oe_o,
    output logic sda_rx_o,
    output logic ext_ref_sel_o,
    output logic analog_pd_o,
    output logic external_clock_in_sel_o,
    output logic osc_en_o,
    output logic sample_tick_o,
    output logic step_dir_o,
    output logic [lcf_pkg::STEP_BITS-1:0] hue_pos_o,
    output logic [lcf_pkg::STEP_BITS-1:0] lum_level_o
);
    import lcf_pkg::*;

    typedef struct packed {
        lcf_btn_e btn;
        logic [31:0] hold_cnt;
        logic [31:0] tick_cnt;
        logic dir_up;
        logic [STEP_BITS-1:0] hue;
        logic [STEP_BITS-1:0] lum;
        logic sample_tick;
        logic err_flag;
        logic [ERR_BITS-1:0] err_status;
        logic [ADDR_BITS-1:0] addr;
        logic ext_ref;
        logic analog_pd;
        logic external_clock_in;
        logic osc_en;
        logic sda_oe;
        logic sda_rx;
        logic sda_dat;
    } lcf_top_s;

    lcf_top_s st_ff;
    lcf_top_s nxt_st;

    logic core_en;
    logic both_held;
    logic step_tick;

    lcf_pwm_if #(.W(PWM_BITS)) pwm_bus ();

    // Sleep is modelled as a clock enable: the core sees no edges while it is low
    assign core_en = !low_power_req_i; // RULE_03
    assign both_held = hue_step_button_i && luminance_step_button_i;
    assign step_tick = (st_ff.tick_cnt == 32'(SAMPLE_CYC_P - 1));

    assign pwm_bus.duty = {duty_blue_i, duty_green_i, duty_red_i};
    assign pwm_bus.run = pwm_run_bit_i; // RULE_20
    assign pwm_bus.polarity = pwm_polarity_bit_i; // RULE_14
    assign pwm_bus.en = core_en; // RULE_03

    lcf_pwm_gen #(.PRESC(PWM_PRESC_P), .W(PWM_BITS)) u_pwm (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pif(pwm_bus)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sample_tick = 1'b0;
        nxt_st.analog_pd = low_power_req_i; // RULE_03
        nxt_st.external_clock_in = clk_sel_i; // RULE_04
        // Oscillator runs only when selected and not asleep
        nxt_st.osc_en = !clk_sel_i && !low_power_req_i; // RULE_04 RULE_03
        // Data pin is open drain: only ever pulled low, and let go while asleep so the bus is not held
        nxt_st.sda_oe = core_en && sda_drive_low_req_i; // RULE_07
        if (core_en) begin
            nxt_st.tick_cnt = step_tick ? 32'h0 : st_ff.tick_cnt + 32'h1;
            nxt_st.sample_tick = step_tick && pwm_run_bit_i; // RULE_21 RULE_20
            nxt_st.err_flag = |err_cond_i; // RULE_16
            nxt_st.err_status = err_cond_i; // RULE_17
            nxt_st.ext_ref = reference_source_bit_i; // RULE_18
            nxt_st.sda_rx = sda_i;
            unique case (st_ff.btn)
                LCF_BTN_IDLE: begin
                    if (both_held) begin
                        nxt_st.btn = LCF_BTN_HOLD;
                        nxt_st.hold_cnt = 32'h1;
                    end else if (step_tick && hue_step_button_i) begin
                        nxt_st.hue = lcf_step(st_ff.hue, st_ff.dir_up, 1'b1); // RULE_08 RULE_10
                    end else if (step_tick && luminance_step_button_i) begin
                        nxt_st.lum = lcf_step(st_ff.lum, st_ff.dir_up, 1'b0); // RULE_11
                    end
                end
                LCF_BTN_HOLD: begin
                    if (!both_held) begin
                        // A short overlap is dropped without stepping or reversing
                        nxt_st.btn = LCF_BTN_IDLE;
                        nxt_st.hold_cnt = 32'h0;
                    end else if (st_ff.hold_cnt == 32'(REV_HOLD_CYC_P - 1)) begin
                        nxt_st.dir_up = !st_ff.dir_up; // RULE_09 RULE_10 RULE_11
                        nxt_st.btn = LCF_BTN_DONE;
                    end else begin
                        nxt_st.hold_cnt = st_ff.hold_cnt + 32'h1;
                    end
                end
                LCF_BTN_DONE: begin
                    // One reversal per hold; both buttons must come free before stepping again
                    if (!hue_step_button_i && !luminance_step_button_i) begin
                        nxt_st.btn = LCF_BTN_IDLE;
                        nxt_st.hold_cnt = 32'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            // Straps are caught while reset is held, so a strap moved later cannot renumber the part
            st_ff <= '{btn: LCF_BTN_IDLE, hold_cnt: 32'h0, tick_cnt: 32'h0, dir_up: DIR_RST,
                       hue: HUE_RST, lum: LUM_RST, sample_tick: 1'b0, err_flag: 1'b0,
                       err_status: '0, addr: {ADDR_UPPER, addr_strap_hi_i, addr_strap_lo_i}, ext_ref: 1'b0,
                       analog_pd: 1'b0, external_clock_in: 1'b0, osc_en: 1'b0, sda_oe: 1'b0, sda_rx: 1'b1,
                       sda_dat: 1'b0}; // RULE_01 RULE_05 RULE_06
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pwm_red_o = pwm_bus.pwm[0]; // RULE_12
    assign pwm_green_o = pwm_bus.pwm[1];
    assign pwm_blue_o = pwm_bus.pwm[2];
    assign pwm_period_start_o = pwm_bus.period_start;
    assign slave_addr_o = st_ff.addr; // RULE_05 RULE_06
    // Open drain: the pin level is always low, only its enable moves
    assign sda_o = st_ff.sda_dat;
    assign err_flag_o = st_ff.err_flag;
    assign error_status_o = st_ff.err_status;
    assign sda_oe_o = st_ff.sda_oe;
    assign sda_rx_o = st_ff.sda_rx;
    assign ext_ref_sel_o = st_ff.ext_ref;
    assign analog_pd_o = st_ff.analog_pd;
    assign external_clock_in_sel_o = st_ff.external_clock_in;
    assign osc_en_o = st_ff.osc_en;
    assign sample_tick_o = st_ff.sample_tick;
    assign step_dir_o = st_ff.dir_up;
    assign hue_pos_o = st_ff.hue;
    assign lum_level_o = st_ff.lum;

    property p_reset_values;
        @(posedge sys_clk_i) disable iff (reset_i)
            $past(reset_i) |-> (st_ff.hue == HUE_RST && st_ff.lum == LUM_RST && st_ff.dir_up == DIR_RST
                                && !err_flag_o && st_ff.btn == LCF_BTN_IDLE);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("State not at reset value"); // RULE_01

    property p_sleep_freeze;
        @(posedge sys_clk_i) disable iff (reset_i)
            $past(low_power_req_i) && !$past(reset_i) |->
                $stable(st_ff.hue) && $stable(st_ff.lum) && $stable(st_ff.tick_cnt) && analog_pd_o;
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("Core moved during sleep"); // RULE_03

    property p_clk_sel;
        @(posedge sys_clk_i) disable iff (reset_i)
            !$past(reset_i) |-> external_clock_in_sel_o == $past(clk_sel_i) && (osc_en_o -> !external_clock_in_sel_o);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("Clock source select wrong"); // RULE_04

    property p_addr;
        @(posedge sys_clk_i) disable iff (reset_i)
            $past(reset_i) |-> slave_addr_o == {ADDR_UPPER, $past(addr_strap_hi_i), $past(addr_strap_lo_i)};
    endproperty
    a_addr: assert property (p_addr) else $error("Slave address not formed from straps"); // RULE_05 RULE_06

    property p_sda_dir;
        @(posedge sys_clk_i) disable iff (reset_i)
            sda_oe_o |-> $past(sda_drive_low_req_i) && $past(core_en) && !sda_o;
    endproperty
    a_sda_dir: assert property (p_sda_dir) else $error("Data pin driven without request"); // RULE_07

    property p_hue_step;
        @(posedge sys_clk_i) disable iff (reset_i)
            (core_en && step_tick && st_ff.btn == LCF_BTN_IDLE && hue_step_button_i && !luminance_step_button_i)
                |=> st_ff.hue == lcf_step($past(st_ff.hue), $past(st_ff.dir_up), 1'b1);
    endproperty
    a_hue_step: assert property (p_hue_step) else $error("Hue did not step in current direction"); // RULE_08 RULE_10

    property p_lum_step;
        @(posedge sys_clk_i) disable iff (reset_i)
            (core_en && step_tick && st_ff.btn == LCF_BTN_IDLE && luminance_step_button_i && !hue_step_button_i)
                |=> st_ff.lum == lcf_step($past(st_ff.lum), $past(st_ff.dir_up), 1'b0) && $stable(st_ff.hue);
    endproperty
    a_lum_step: assert property (p_lum_step) else $error("Brightness did not step"); // RULE_11

    property p_reverse;
        @(posedge sys_clk_i) disable iff (reset_i)
            $changed(st_ff.dir_up) |-> $past(st_ff.hold_cnt) == 32'(REV_HOLD_CYC_P - 1) && $past(both_held);
    endproperty
    a_reverse: assert property (p_reverse) else $error("Direction flipped without full hold"); // RULE_09

    property p_err;
        @(posedge sys_clk_i) disable iff (reset_i)
            $past(core_en) && !$past(reset_i) |-> err_flag_o == (|$past(err_cond_i)) &&
                error_status_o == $past(err_cond_i);
    endproperty
    a_err: assert property (p_err) else $error("Error flag or status wrong"); // RULE_16 RULE_17

    property p_ref;
        @(posedge sys_clk_i) disable iff (reset_i)
            $past(core_en) && !$past(reset_i) |-> ext_ref_sel_o == $past(reference_source_bit_i);
    endproperty
    a_ref: assert property (p_ref) else $error("Reference select not followed"); // RULE_18

    property p_sample;
        @(posedge sys_clk_i) disable iff (reset_i)
            sample_tick_o |-> $past(pwm_run_bit_i) && $past(st_ff.tick_cnt) == 32'(SAMPLE_CYC_P - 1);
    endproperty
    a_sample: assert property (p_sample) else $error("Sample tick off schedule"); // RULE_21

    property p_sleep_outputs;
        @(posedge sys_clk_i) disable iff (reset_i)
            $past(low_power_req_i) && !$past(reset_i) |-> !osc_en_o && !sda_oe_o;
    endproperty
    a_sleep_outputs: assert property (p_sleep_outputs) else $error("Clock or data pin active in sleep"); // RULE_03

    property p_addr_kept;
        @(posedge sys_clk_i) disable iff (reset_i)
            !$past(reset_i) |-> $stable(slave_addr_o);
    endproperty
    a_addr_kept: assert property (p_addr_kept) else $error("Slave address moved after reset"); // RULE_05

    // A counter past its terminal count would not tick again until its 32 bits wrapped round
    property p_tick_bound;
        @(posedge sys_clk_i) disable iff (reset_i)
            st_ff.tick_cnt < 32'(SAMPLE_CYC_P);
    endproperty
    a_tick_bound: assert property (p_tick_bound) else $error("Sample counter overran"); // RULE_21

    property p_no_step_busy;
        @(posedge sys_clk_i) disable iff (reset_i)
            st_ff.btn != LCF_BTN_IDLE |=> $stable(st_ff.hue) && $stable(st_ff.lum);
    endproperty
    a_no_step_busy: assert property (p_no_step_busy) else $error("Step while both buttons held"); // RULE_09

    property p_one_flip;
        @(posedge sys_clk_i) disable iff (reset_i)
            st_ff.btn == LCF_BTN_DONE && $past(st_ff.btn) == LCF_BTN_DONE |-> $stable(st_ff.dir_up);
    endproperty
    a_one_flip: assert property (p_one_flip) else $error("Direction flipped twice in one hold"); // RULE_09

    property p_short_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
            core_en && st_ff.btn == LCF_BTN_HOLD && !both_held |=> st_ff.btn == LCF_BTN_IDLE && $stable(st_ff.dir_up);
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("Short hold not dropped"); // RULE_09
endmodule : lcf_ctrl_top

/* lcf_led_load_model.sv */
`timescale 1ns/100ps
// Far side of the block: three LED driver enables and the serial host sharing the data pin
module lcf_led_load_model (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [2:0] pwm_i,
    input wire logic polarity_i,
    input wire logic period_start_i,
    input wire logic sda_oe_i,
    input wire logic sda_dev_i,
    input wire logic host_sda_low_i,
    output logic sda_line_o,
    output logic [2:0][15:0] on_cnt_o,
    output logic [15:0] period_len_o
);
    logic [2:0][15:0] acc_ff;
    logic [15:0] len_ff;

    // Pull-up on the pin: a released line reads high, never its last driven value
    assign sda_line_o = ((sda_oe_i && !sda_dev_i) || host_sda_low_i) ? 1'b0 : 1'b1;

    // Counts are reported at each period start; the first report covers every cycle since reset, not one whole period
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            acc_ff <= '0;
            len_ff <= 16'h0000;
            on_cnt_o <= '0;
            period_len_o <= 16'h0000;
        end else if (period_start_i) begin
            period_len_o <= len_ff;
            len_ff <= 16'h0001;
            for (int c = 0; c < 3; c++) begin
                on_cnt_o[c] <= acc_ff[c];
                acc_ff[c] <= {15'h0000, pwm_i[c] ^ polarity_i};
            end
        end else begin
            len_ff <= len_ff + 16'h0001;
            for (int c = 0; c < 3; c++) begin
                acc_ff[c] <= acc_ff[c] + {15'h0000, pwm_i[c] ^ polarity_i};
            end
        end
    end
endmodule : lcf_led_load_model

/* lcf_ctrl_top_bench.sv */
`timescale 1ns/100ps
module lcf_ctrl_top_bench;
    import lcf_pkg::*;
    localparam int SCYC = 16;
    localparam int RCYC = 20;
    localparam int PRE = 1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lp = 1'b0, csel = 1'b0, shi = 1'b1, slo = 1'b0, sda_line, drv_low = 1'b0, host_low = 1'b0;
    logic hue_b = 1'b0, lum_b = 1'b0, pol = 1'b0, run = 1'b0, vref = 1'b0;
    logic [11:0] dr = 12'h100, dg = 12'h000, db = 12'hfff;
    logic [2:0] err = 3'h0;
    logic pwm_r, pwm_g, pwm_b, pstart, flag, sda_o, sda_oe, sda_rx, ext_ref, apd, external_clock_in, osc_en, tick_o, dir;
    logic [2:0] status;
    logic [6:0] addr;
    logic [7:0] hue, lum;
    logic [2:0][15:0] on_cnt;
    logic [15:0] plen;
    int fail_count = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    lcf_ctrl_top #(.SAMPLE_CYC_P(SCYC), .REV_HOLD_CYC_P(RCYC), .PWM_PRESC_P(PRE)) dut_u (
        .sys_clk_i(clk), .reset_i(rst), .low_power_req_i(lp), .clk_sel_i(csel),
        .addr_strap_hi_i(shi), .addr_strap_lo_i(slo), .sda_i(sda_line), .sda_drive_low_req_i(drv_low),
        .hue_step_button_i(hue_b), .luminance_step_button_i(lum_b), .pwm_polarity_bit_i(pol),
        .pwm_run_bit_i(run), .reference_source_bit_i(vref), .duty_red_i(dr), .duty_green_i(dg),
        .duty_blue_i(db), .err_cond_i(err), .pwm_red_o(pwm_r), .pwm_green_o(pwm_g), .pwm_blue_o(pwm_b),
        .pwm_period_start_o(pstart), .err_flag_o(flag), .error_status_o(status), .slave_addr_o(addr),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .sda_rx_o(sda_rx), .ext_ref_sel_o(ext_ref), .analog_pd_o(apd),
        .external_clock_in_sel_o(external_clock_in), .osc_en_o(osc_en), .sample_tick_o(tick_o), .step_dir_o(dir),
        .hue_pos_o(hue), .lum_level_o(lum)
    );

    lcf_led_load_model load_u (
        .sys_clk_i(clk), .reset_i(rst), .pwm_i({pwm_b, pwm_g, pwm_r}), .polarity_i(pol),
        .period_start_i(pstart), .sda_oe_i(sda_oe), .sda_dev_i(sda_o), .host_sda_low_i(host_low),
        .sda_line_o(sda_line), .on_cnt_o(on_cnt), .period_len_o(plen)
    );

    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wait_period();
        int k;
        k = 0;
        tick(1);
        while (pstart !== 1'b1 && k < 9000) begin
            tick(1);
            k++;
        end
        // The load model closes its period count one edge after the start pulse
        tick(1);
        if (k >= 9000) begin
            chk("period start", 16'h0001, 16'h0000);
        end
    endtask : wait_period

    // Release lands midway between two sample ticks, so the step count cannot be off by one
    task automatic press(input logic h, input logic l, input int n);
        logic [7:0] start;
        int k;
        start = h ? hue : lum;
        hue_b = h;
        lum_b = l;
        k = 0;
        while ((h ? hue : lum) === start && k < 3 * SCYC) begin
            tick(1);
            k++;
        end
        tick(SCYC * (n - 1) + SCYC / 2);
        hue_b = 1'b0;
        lum_b = 1'b0;
        tick(2);
    endtask : press

    task automatic hold_both(input int n);
        hue_b = 1'b1;
        lum_b = 1'b1;
        tick(n);
        hue_b = 1'b0;
        lum_b = 1'b0;
        tick(2);
    endtask : hold_both

    task automatic count_ticks(input logic [15:0] exp);
        int seen;
        seen = 0;
        repeat (SCYC * 4) begin
            tick(1);
            if (tick_o === 1'b1) begin
                seen++;
            end
        end
        chk("sample_tick count", exp, 16'(seen));
    endtask : count_ticks

    initial begin
        #(600_000);
        fail_count++;
        summarize();
    end

    initial begin
        tick(2);
        chk("step_dir", 16'h0001, {15'h0000, dir});
        chk("lum_level", 16'h0080, {8'h00, lum});
        chk("hue_pos", 16'h0000, {8'h00, hue});
        chk("pwm idle", 16'h0000, {13'h0000, pwm_b, pwm_g, pwm_r});
        chk("slave_addr", {9'h000, 5'h15, shi, slo}, {9'h000, addr});
        rst = 1'b0;
        vref = 1'b1;
        csel = 1'b1;
        tick(2);
        chk("ext_ref_sel", 16'h0001, {15'h0000, ext_ref});
        chk("external_clock_in_sel", 16'h0001, {15'h0000, external_clock_in});
        chk("osc_en", 16'h0000, {15'h0000, osc_en});
        vref = 1'b0;
        csel = 1'b0;
        tick(2);
        chk("ext_ref_sel", 16'h0000, {15'h0000, ext_ref});
        chk("osc_en", 16'h0001, {15'h0000, osc_en});
        for (int e = 0; e < 8; e++) begin
            err = 3'(e);
            tick(2);
            chk("err_flag", {15'h0000, err != 3'h0}, {15'h0000, flag});
            chk("error_status", {13'h0000, err}, {13'h0000, status});
        end
        err = 3'h0;
        host_low = 1'b1;
        tick(2);
        chk("sda_rx host low", 16'h0000, {15'h0000, sda_rx});
        host_low = 1'b0;
        drv_low = 1'b1;
        tick(2);
        chk("sda_oe", 16'h0001, {15'h0000, sda_oe});
        chk("sda_rx own low", 16'h0000, {15'h0000, sda_o | sda_rx});
        drv_low = 1'b0;
        tick(2);
        chk("sda released", 16'h0001, {15'h0000, !sda_oe && sda_rx});
        press(1'b1, 1'b0, 3);
        chk("hue up", 16'h0003, {8'h00, hue});
        press(1'b0, 1'b1, 2);
        chk("lum up", 16'h0082, {8'h00, lum});
        hold_both(RCYC / 2);
        chk("dir short hold", 16'h0001, {15'h0000, dir});
        hold_both(RCYC * 3);
        chk("dir long hold", 16'h0000, {15'h0000, dir});
        chk("no step while both", 16'h0382, {hue, lum});
        press(1'b1, 1'b0, 5);
        chk("hue down wrap", 16'h00fe, {8'h00, hue});
        press(1'b0, 1'b1, 140);
        chk("lum floor", 16'h0000, {8'h00, lum});
        lp = 1'b1;
        hue_b = 1'b1;
        tick(SCYC * 4);
        chk("analog_pd", 16'h0001, {15'h0000, apd});
        chk("hue frozen", 16'h00fe, {8'h00, hue});
        hue_b = 1'b0;
        lp = 1'b0;
        tick(2);
        chk("analog_pd off", 16'h0000, {15'h0000, apd});
        // Duties were set before run, so the first boundary already latches them
        run = 1'b1;
        count_ticks(16'h0004);
        wait_period();
        wait_period();
        chk("period length", 16'(PRE) * 16'h1000, plen);
        chk("red on", 16'(PRE) * {4'h0, dr}, on_cnt[0]);
        chk("green on", 16'(PRE) * {4'h0, dg}, on_cnt[1]);
        chk("blue on", 16'(PRE) * {4'h0, db}, on_cnt[2]);
        tick(100);
        dr = 12'h040;
        wait_period();
        chk("red old duty", 16'(PRE) * 16'h0100, on_cnt[0]);
        wait_period();
        chk("red new duty", 16'(PRE) * 16'h0040, on_cnt[0]);
        pol = 1'b1;
        wait_period();
        wait_period();
        chk("red on inverted", 16'(PRE) * 16'h0040, on_cnt[0]);
        chk("blue on inverted", 16'(PRE) * {4'h0, db}, on_cnt[2]);
        run = 1'b0;
        tick(3);
        chk("idle high level", 16'h0007, {13'h0000, pwm_b, pwm_g, pwm_r});
        pol = 1'b0;
        tick(3);
        chk("idle low level", 16'h0000, {13'h0000, pwm_b, pwm_g, pwm_r});
        count_ticks(16'h0000);
        shi = 1'b0;
        slo = 1'b1;
        rst = 1'b1;
        tick(RST_MIN_CYC);
        chk("hue after reset", 16'h0000, {8'h00, hue});
        chk("dir after reset", 16'h0001, {15'h0000, dir});
        chk("lum after reset", 16'h0080, {8'h00, lum});
        rst = 1'b0;
        shi = 1'b1;
        tick(2);
        chk("slave_addr kept", 16'h0055, {9'h000, addr});
        summarize();
    end
endmodule : lcf_ctrl_top_bench
